// file: rtl/fp_post_compute_exception_unit.v
`timescale 1ns/1ps
`include "fpx_defs.vh"

// What this block does
// - overflow when rounded magnitude reaches 2^128, 2^1024 or 2^16384 by format
// - masked overflow sets its flag and substitutes a result, no handler
// - substitute is infinity or largest finite, chosen by rounding mode and sign
// - unmasked overflow flags, calls handler; vector and memory unchanged, stack register gets biased result
// - tiny means non-zero and below 2^-126, 2^-1022 or 2^-16382
// - stack tininess uses exponent rounded at precision-control precision
// - masked underflow flags only when tiny and inexact
// - masked tiny result is written as correctly signed small value always
// - unmasked underflow flags every non-zero tiny result
// - unmasked underflow calls handler; vector and memory unchanged, stack register gets biased result
// - inexact alone with precision masked flags and stores rounded result
// - inexact alone with precision unmasked flags, stores, then calls handler
// - inexact with masked overflow/underflow sets both flags, handler if precision unmasked
// - inexact with unmasked overflow/underflow to register sets both, calls handler
// - unmasked overflow/underflow on memory store hides inexact, clears condition bit one
// - flags stay set until software clears them
// - flags at bits 0 to 5, masks at bits 7 to 12
// - post checks run only after pre-computation checks pass
module fp_post_compute_exception_unit (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // datapath side
  input  wire        i_res_valid,
  input  wire        i_pre_abort,
  input  wire [1:0]  i_fmt,
  input  wire        i_env_vector,
  input  wire        i_dst_mem,
  input  wire        i_sign,
  input  wire        i_nonzero,
  input  wire        i_inexact,
  input  wire [17:0] i_exp_dst,
  input  wire [17:0] i_exp_pc,
  // results to datapath and trap dispatch
  output reg         o_out_valid,
  output reg  [2:0]  o_res_kind,
  output reg         o_res_sign,
  output reg         o_dst_write,
  output reg         o_handler_req,
  output reg         o_c1_clear,
  output reg  [1:0]  o_rc,
  output reg  [1:0]  o_pc,
  output reg         o_irq,
  // avalon-mm slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest
);

  reg  [31:0]           csr_r;
  reg  [31:0]           csr_nxt;
  reg  [`IRQ_W-1:0]     irq_status_r;
  reg  [`IRQ_W-1:0]     irq_status_nxt;
  reg  [`IRQ_W-1:0]     irq_mask_r;
  reg  [`IRQ_W-1:0]     irq_mask_nxt;
  reg  [15:0]           last_r;
  reg  [15:0]           last_nxt;

  wire                  bus_req;
  wire                  bus_go;
  wire                  wr_go;
  wire [31:0]           be_mask;
  wire [5:0]            mask;
  wire [1:0]            rc;
  wire [1:0]            pc;

  wire                  ovf_sgl;
  wire                  ovf_dbl;
  wire                  ovf_ext;
  wire                  tiny_sgl;
  wire                  tiny_dbl;
  wire                  tiny_ext;
  reg                   ovf_hit;
  reg                   tiny_hit;
  wire signed [17:0]    exp_dst;
  wire signed [17:0]    exp_tiny;
  wire                  check;
  wire                  ovf;
  wire                  tiny;
  wire                  ovf_unmasked;
  wire                  unf_unmasked;
  wire                  any_unmasked;
  wire                  set_ovf;
  wire                  set_unf;
  wire                  set_pe;
  wire                  handler;
  wire                  c1_clear;
  reg  [2:0]            kind;
  reg  [2:0]            ovf_kind;
  wire [5:0]            flag_set;
  wire [`IRQ_W-1:0]     irq_event;
  wire [15:0]           last_fields;
  reg                   out_valid_nxt;
  reg  [2:0]            res_kind_nxt;
  reg                   res_sign_nxt;
  reg                   dst_write_nxt;
  reg                   handler_req_nxt;
  reg                   c1_clear_nxt;
  reg                   csr_hit;
  reg                   status_hit;
  reg                   mask_hit;
  reg                   rdata_load;
  reg  [31:0]           rdata_nxt;
  reg                   waitreq_nxt;
  reg                   irq_nxt;

  assign mask = csr_r[`CSR_MASK_LSB +: 6];
  assign rc   = csr_r[`CSR_RC_LSB +: 2];
  assign pc   = csr_r[`CSR_PC_LSB +: 2];

  // ---------------------------------------------------------------- detection
  // every format is judged at once; the format field only picks which verdict counts
  assign ovf_sgl  = (exp_dst >= $signed(`OVF_EXP_SGL));
  assign ovf_dbl  = (exp_dst >= $signed(`OVF_EXP_DBL));
  assign ovf_ext  = (exp_dst >= $signed(`OVF_EXP_EXT));
  assign tiny_sgl = (exp_tiny < $signed(`TINY_EXP_SGL));
  assign tiny_dbl = (exp_tiny < $signed(`TINY_EXP_DBL));
  assign tiny_ext = (exp_tiny < $signed(`TINY_EXP_EXT));

  always @* begin
    case (i_fmt)
      `FMT_SINGLE: begin
        ovf_hit  = ovf_sgl;
        tiny_hit = tiny_sgl;
      end
      `FMT_DOUBLE: begin
        ovf_hit  = ovf_dbl;
        tiny_hit = tiny_dbl;
      end
      default: begin
        ovf_hit  = ovf_ext;
        tiny_hit = tiny_ext;
      end
    endcase
  end

  assign exp_dst  = i_exp_dst;
  // stack results are judged tiny after rounding to the precision-control width
  assign exp_tiny = i_env_vector ? i_exp_dst : i_exp_pc;

  // nothing is judged for a result whose instruction already trapped earlier
  assign check = i_res_valid & ~i_pre_abort;

  assign ovf  = check & i_nonzero & ovf_hit;
  // overflow takes precedence, a value cannot be both
  assign tiny = check & i_nonzero & ~ovf & tiny_hit;

  assign ovf_unmasked = ovf & ~mask[`FL_OVERFLOW];
  assign unf_unmasked = tiny & ~mask[`FL_UNDERFLOW];
  assign any_unmasked = ovf_unmasked | unf_unmasked;

  assign set_ovf = ovf;
  // masked: tiny and inexact; unmasked: any non-zero tiny result
  assign set_unf = tiny & (unf_unmasked | i_inexact);
  // a trapped store to memory keeps the inexact condition silent
  assign set_pe  = check & i_inexact & ~(any_unmasked & i_dst_mem);

  assign handler  = any_unmasked | (set_pe & ~mask[`FL_PRECISION]);
  assign c1_clear = any_unmasked & i_dst_mem;

  // masked overflow: infinity for round-to-nearest, else only when rounding heads toward the result's own infinity
  always @* begin
    ovf_kind = `RES_MAX_FINITE;
    case (rc)
      `RC_NEAREST: ovf_kind = `RES_INF;
      `RC_DOWN: begin
        if (i_sign)
          ovf_kind = `RES_INF;
        else
          ovf_kind = `RES_MAX_FINITE;
      end
      `RC_UP: begin
        if (i_sign)
          ovf_kind = `RES_MAX_FINITE;
        else
          ovf_kind = `RES_INF;
      end
      `RC_ZERO:    ovf_kind = `RES_MAX_FINITE;
      default:     ovf_kind = `RES_INF;
    endcase
  end

  always @* begin
    if (any_unmasked) begin
      // vector ops leave operands untouched; stack register ops get a biased value
      if (i_env_vector | i_dst_mem)
        kind = `RES_UNCHANGED;
      else
        kind = `RES_BIASED;
    end else if (ovf) begin
      kind = ovf_kind;
    end else if (tiny) begin
      kind = `RES_TINY;
    end else begin
      kind = `RES_ROUNDED;
    end
  end

  assign flag_set    = {set_pe, set_unf, set_ovf, 3'b000};
  assign irq_event   = {set_pe, set_unf, set_ovf, handler};
  assign last_fields = {6'h00, c1_clear, handler, tiny, ovf, set_pe, i_sign, 1'b0, kind};

  // datapath outputs are one-cycle pulses; idle cycles show a plain rounded result
  always @* begin
    out_valid_nxt   = 1'b0;
    res_kind_nxt    = `RES_ROUNDED;
    res_sign_nxt    = 1'b0;
    dst_write_nxt   = 1'b0;
    handler_req_nxt = 1'b0;
    c1_clear_nxt    = 1'b0;
    if (check) begin
      out_valid_nxt   = 1'b1;
      res_kind_nxt    = kind;
      res_sign_nxt    = i_sign;
      dst_write_nxt   = (kind != `RES_UNCHANGED);
      handler_req_nxt = handler;
      c1_clear_nxt    = c1_clear;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_valid   <= 1'b0;
      o_res_kind    <= `RES_ROUNDED;
      o_res_sign    <= 1'b0;
      o_dst_write   <= 1'b0;
      o_handler_req <= 1'b0;
      o_c1_clear    <= 1'b0;
    end else begin
      o_out_valid   <= out_valid_nxt;
      o_res_kind    <= res_kind_nxt;
      o_res_sign    <= res_sign_nxt;
      o_dst_write   <= dst_write_nxt;
      o_handler_req <= handler_req_nxt;
      o_c1_clear    <= c1_clear_nxt;
    end
  end

  // ---------------------------------------------------------------- register bus
  assign bus_req = i_avs_read | i_avs_write;
  // first cycle of a request sees waitrequest high; the answer comes one cycle later
  assign bus_go  = bus_req & o_avs_waitrequest;
  assign wr_go   = i_avs_write & ~o_avs_waitrequest;
  assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // one address decode serves the write path and the read mux
  always @* begin
    csr_hit    = 1'b0;
    status_hit = 1'b0;
    mask_hit   = 1'b0;
    case (i_avs_address)
      `OFF_CSR:        csr_hit    = 1'b1;
      `OFF_IRQ_STATUS: status_hit = 1'b1;
      `OFF_IRQ_MASK:   mask_hit   = 1'b1;
      default:         csr_hit    = 1'b0;
    endcase
  end

  always @* begin
    csr_nxt = csr_r;
    if (wr_go & csr_hit)
      csr_nxt = (csr_r & ~(be_mask & `CSR_WR_MASK)) |
                (i_avs_writedata & be_mask & `CSR_WR_MASK);
    // hardware sets land after the software write so a same-cycle event is kept
    csr_nxt[`CSR_FLAG_LSB +: 6] = csr_nxt[`CSR_FLAG_LSB +: 6] | flag_set;
  end

  always @* begin
    irq_status_nxt = irq_status_r;
    if (wr_go & status_hit & i_avs_byteenable[0])
      irq_status_nxt = irq_status_r & ~i_avs_writedata[`IRQ_W-1:0];
    // set after clear, so an event in the clearing cycle survives
    if (check)
      irq_status_nxt = irq_status_nxt | irq_event;
  end

  always @* begin
    irq_mask_nxt = irq_mask_r;
    if (wr_go & mask_hit & i_avs_byteenable[0])
      irq_mask_nxt = i_avs_writedata[`IRQ_W-1:0];
  end

  always @* begin
    last_nxt = last_r;
    if (check)
      last_nxt = last_fields;
  end

  // read data is loaded on the wait cycle and then holds until the next read
  always @* begin
    waitreq_nxt = ~bus_go;
    irq_nxt     = |(irq_status_nxt & irq_mask_nxt);
    rdata_load  = bus_go & i_avs_read;
    rdata_nxt   = o_avs_readdata;
    if (rdata_load) begin
      if (csr_hit)
        rdata_nxt = csr_r;
      else if (status_hit)
        rdata_nxt = {28'h0000000, irq_status_r};
      else if (mask_hit)
        rdata_nxt = {28'h0000000, irq_mask_r};
      else if (i_avs_address == `OFF_LAST)
        rdata_nxt = {16'h0000, last_r};
      else
        rdata_nxt = 32'h00000000;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      csr_r        <= `CSR_RESET;
      irq_status_r <= {`IRQ_W{1'b0}};
      irq_mask_r   <= {`IRQ_W{1'b0}};
      last_r       <= 16'h0000;
    end else begin
      csr_r        <= csr_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r   <= irq_mask_nxt;
      last_r       <= last_nxt;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
      o_irq             <= 1'b0;
      o_rc              <= `RC_NEAREST;
      o_pc              <= 2'h0;
    end else begin
      o_avs_waitrequest <= waitreq_nxt;
      o_avs_readdata    <= rdata_nxt;
      o_irq             <= irq_nxt;
      o_rc              <= csr_nxt[`CSR_RC_LSB +: 2];
      o_pc              <= csr_nxt[`CSR_PC_LSB +: 2];
    end
  end

endmodule

// file: rtl/fpx_defs.vh
`ifndef FPX_DEFS_VH
`define FPX_DEFS_VH

// register byte offsets
`define OFF_CSR         4'h0
`define OFF_IRQ_STATUS  4'h4
`define OFF_IRQ_MASK    4'h8
`define OFF_LAST        4'hc

// control/status register fields
`define CSR_FLAG_LSB    0
`define CSR_MASK_LSB    7
`define CSR_RC_LSB      13
`define CSR_PC_LSB      16
`define CSR_RESET       32'h00001f80
`define CSR_WR_MASK     32'h00037fbf

// flag positions inside the six-bit flag and mask fields
`define FL_INVALID      0
`define FL_DENORM       1
`define FL_ZERODIV      2
`define FL_OVERFLOW     3
`define FL_UNDERFLOW    4
`define FL_PRECISION    5

// interrupt status bits
`define IRQ_HANDLER     0
`define IRQ_OVERFLOW    1
`define IRQ_UNDERFLOW   2
`define IRQ_PRECISION   3
`define IRQ_W           4

// formats
`define FMT_SINGLE      2'h0
`define FMT_DOUBLE      2'h1
`define FMT_EXTENDED    2'h2

// rounding modes
`define RC_NEAREST      2'h0
`define RC_DOWN         2'h1
`define RC_UP           2'h2
`define RC_ZERO         2'h3

// result kinds handed back to the datapath
`define RES_ROUNDED     3'h0
`define RES_INF         3'h1
`define RES_MAX_FINITE  3'h2
`define RES_TINY        3'h3
`define RES_BIASED      3'h4
`define RES_UNCHANGED   3'h5

// unbiased exponent thresholds, 18-bit two's complement
`define EXP_W           18
`define OVF_EXP_SGL     18'h00080
`define OVF_EXP_DBL     18'h00400
`define OVF_EXP_EXT     18'h04000
`define TINY_EXP_SGL    18'h3ff82
`define TINY_EXP_DBL    18'h3fc02
`define TINY_EXP_EXT    18'h3c002

`endif

// file: bench/fpx_post_properties.sv
`timescale 1ns/1ps
module fpx_post_chk (
  input logic       i_clk_sys,
  input logic       i_rst_n,
  input logic       i_res_valid,
  input logic       i_pre_abort,
  input logic       i_env_vector,
  input logic       i_dst_mem,
  input logic       i_sign,
  input logic       i_nonzero,
  input logic       o_out_valid,
  input logic [2:0] o_res_kind,
  input logic       o_res_sign,
  input logic       o_dst_write,
  input logic       o_handler_req,
  input logic       o_c1_clear
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire tk = i_res_valid & ~i_pre_abort;
  take_answer_a: assert property (tk |=> o_out_valid) else $error("no answer");
  abort_quiet_a:
    assert property (!tk |=> !o_out_valid && !o_handler_req) else $error("answer without result");
  sign_follow_a: assert property (tk |=> o_res_sign == $past(i_sign)) else $error("sign");
  write_kind_a:
    assert property (o_out_valid |-> o_dst_write == (o_res_kind != 3'h5)) else $error("write kind");
  c1_clear_a:
    assert property (o_c1_clear |-> o_handler_req && o_res_kind == 3'h5 && $past(i_dst_mem))
    else $error("c1 clear");
  unmasked_call_a:
    assert property (o_out_valid && o_res_kind >= 3'h4 |-> o_handler_req) else $error("no handler");
  vector_unch_a:
    assert property (tk && i_env_vector |=> o_res_kind != 3'h4) else $error("vector biased");
  mem_unch_a:
    assert property (tk && i_dst_mem |=> o_res_kind != 3'h4) else $error("memory biased");
  zero_plain_a:
    assert property (tk && !i_nonzero |=> o_res_kind == 3'h0) else $error("zero not plain");
  cover property (o_handler_req);
  cover property (o_c1_clear);
  cover property (o_out_valid && o_res_kind == 3'h1);
endmodule
bind fp_post_compute_exception_unit fpx_post_chk chk_u (.i_clk_sys, .i_rst_n, .i_res_valid,
  .i_pre_abort, .i_env_vector, .i_dst_mem, .i_sign, .i_nonzero, .o_out_valid, .o_res_kind,
  .o_res_sign, .o_dst_write, .o_handler_req, .o_c1_clear);

// file: bench/fpx_dp_model.sv
`timescale 1ns/1ps
module fpx_dp_model (
  input  wire        i_clk_sys,
  output reg         o_res_valid,
  output reg  [43:0] o_op
);
  initial begin
    o_res_valid = 1'b0;
    o_op        = 44'h0;
  end
  // one result per call, environment and memory flag always travel with it
  task issue(input [43:0] v);
    begin
      o_res_valid <= 1'b1;
      o_op        <= v;
      @(posedge i_clk_sys);
      o_res_valid <= 1'b0;
      // stale fields are inverted so nothing can lean on a held value
      o_op        <= ~v;
    end
  endtask
endmodule

// file: bench/fp_post_compute_exception_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module fp_post_compute_exception_unit_tb_top;
  reg         i_clk_sys, i_rst_n, i_avs_read, i_avs_write;
  reg  [3:0]  i_avs_address;
  reg  [31:0] i_avs_writedata, q;
  wire        rv, o_out_valid, o_handler_req, o_c1_clear, o_irq, o_avs_waitrequest;
  wire [2:0]  o_res_kind;
  wire [1:0]  o_rc, o_pc;
  wire [43:0] op;
  wire [31:0] o_avs_readdata;
  integer     checks, n_fail, cyc;
  fpx_dp_model dp_u (.i_clk_sys, .o_res_valid(rv), .o_op(op));
  fp_post_compute_exception_unit dut_u (.i_clk_sys, .i_rst_n, .i_res_valid(rv),
    .i_pre_abort(op[43]), .i_fmt(op[42:41]), .i_env_vector(op[40]), .i_dst_mem(op[39]),
    .i_sign(op[38]), .i_nonzero(op[37]), .i_inexact(op[36]), .i_exp_dst(op[35:18]),
    .i_exp_pc(op[17:0]), .o_out_valid, .o_res_kind, .o_res_sign(), .o_dst_write(),
    .o_handler_req, .o_c1_clear, .o_rc, .o_pc, .o_irq, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf), .o_avs_readdata,
    .o_avs_waitrequest);
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task print_verdict;
    begin
      if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task bus(input r, input [3:0] a, input [31:0] d);
    begin
      i_avs_read <= r;
      i_avs_write <= !r;
      i_avs_address <= a;
      i_avs_writedata <= d;
      @(posedge i_clk_sys);
      while (o_avs_waitrequest !== 1'b0) @(posedge i_clk_sys);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      bus(1'b1, a, 32'h0);
      `CHK(q, e)
    end
  endtask
  // m = {vector, to memory, sign, nonzero, inexact}, hc = {handler, c1 clear}
  task opr(input [1:0] f, input [4:0] m, input [17:0] ed, ep, input [2:0] k, input [1:0] hc);
    begin
      dp_u.issue({1'b0, f, m, ed, ep});
      #1;
      `CHK({o_out_valid, o_res_kind, o_handler_req, o_c1_clear}, {1'b1, k, hc})
      @(posedge i_clk_sys);
    end
  endtask
  task t_regs;
    begin
      rd(4'h0, 32'h00001f80);
      rd(4'h1, 32'h00000000);
      bus(1'b0, 4'h0, 32'h00011f80);
      `CHK(o_pc, 2'h1)
      rd(4'h0, 32'h00011f80);
    end
  endtask
  task t_ovf;
    integer r, s;
    reg [2:0] k;
    begin
      for (r = 0; r < 4; r = r + 1)
        for (s = 0; s < 2; s = s + 1) begin
          k = (r == 0) ? 3'h1 : (r == 3) ? 3'h2 : ((r == 1) == (s == 1)) ? 3'h1 : 3'h2;
          bus(1'b0, 4'h0, 32'h00001f80 | (r << 13));
          `CHK(o_rc, r[1:0])
          opr(2'h0, {2'b10, s[0], 2'b11}, 18'h00080, 18'h00080, k, 2'b00);
          rd(4'h0, 32'h00001fa8 | (r << 13));
        end
    end
  endtask
  task t_thr;
    begin
      bus(1'b0, 4'h0, 32'h00001f80);
      opr(2'h0, 5'b10010, 18'h0007f, 18'h0007f, 3'h0, 2'b00);
      opr(2'h1, 5'b10010, 18'h00400, 18'h00400, 3'h1, 2'b00);
      opr(2'h2, 5'b10010, 18'h03fff, 18'h03fff, 3'h0, 2'b00);
      opr(2'h2, 5'b10010, 18'h04000, 18'h04000, 3'h1, 2'b00);
      rd(4'h0, 32'h00001f88);
    end
  endtask
  task t_unf;
    begin
      bus(1'b0, 4'h0, 32'h00001f80);
      opr(2'h0, 5'b10110, 18'h3ff81, 18'h3ff81, 3'h3, 2'b00);
      rd(4'h0, 32'h00001f80);
      opr(2'h1, 5'b10010, 18'h3fc02, 18'h3fc02, 3'h0, 2'b00);
      opr(2'h2, 5'b10011, 18'h3c001, 18'h3c001, 3'h3, 2'b00);
      opr(2'h0, 5'b10000, 18'h3ff00, 18'h3ff00, 3'h0, 2'b00);
      rd(4'h0, 32'h00001fb0);
    end
  endtask
  task t_unm;
    begin
      bus(1'b0, 4'h0, 32'h00001380);
      opr(2'h0, 5'b10010, 18'h00080, 18'h00080, 3'h5, 2'b10);
      opr(2'h0, 5'b00011, 18'h00080, 18'h00080, 3'h4, 2'b10);
      opr(2'h0, 5'b00010, 18'h00000, 18'h3ff81, 3'h4, 2'b10);
      opr(2'h0, 5'b10010, 18'h00000, 18'h3ff81, 3'h0, 2'b00);
      opr(2'h0, 5'b10010, 18'h3ff81, 18'h3ff81, 3'h5, 2'b10);
      rd(4'h0, 32'h000013b8);
      bus(1'b0, 4'h0, 32'h00001380);
      opr(2'h0, 5'b01011, 18'h3ff81, 18'h3ff81, 3'h5, 2'b11);
      rd(4'h0, 32'h00001390);
    end
  endtask
  task t_pe;
    begin
      bus(1'b0, 4'h0, 32'h00000f80);
      bus(1'b0, 4'h8, 32'h00000001);
      opr(2'h0, 5'b10011, 18'h00000, 18'h00000, 3'h0, 2'b10);
      `CHK(o_irq, 1'b1)
      opr(2'h0, 5'b10011, 18'h00080, 18'h00080, 3'h1, 2'b10);
      bus(1'b0, 4'h4, 32'h0000000f);
      // the level output is registered off the next-state status, so the clear already shows; two more edges are margin
      repeat (2) @(posedge i_clk_sys);
      `CHK(o_irq, 1'b0)
      bus(1'b0, 4'h8, 32'h00000000);
      opr(2'h0, 5'b10011, 18'h00000, 18'h00000, 3'h0, 2'b10);
      `CHK(o_irq, 1'b0)
      rd(4'h4, 32'h00000009);
      rd(4'hc, 32'h00000120);
    end
  endtask
  task t_abort;
    begin
      dp_u.issue({1'b1, 7'h03, 18'h00080, 18'h00080});
      #1;
      `CHK({o_out_valid, o_handler_req}, 2'b00)
      @(posedge i_clk_sys);
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    checks = 0;
    n_fail = 0;
    cyc = 0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    t_regs;
    t_ovf;
    t_thr;
    t_unf;
    t_unm;
    t_pe;
    t_abort;
    print_verdict;
  end
endmodule
